// *** src/pwmc_top.sv ***
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "pwmc_map.svh"
module pwmc_top
#(
	parameter int CHANNEL     = 1,
	parameter int SCAN_CYCLES = `PWMC_SCAN_CYCLES
)
(
	// Clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_b,
	// Register port
	input  wire logic [7:0]             i_addr,
	input  wire logic [31:0]            i_wr_data,
	input  wire logic                   i_wr_en,
	input  wire logic                   i_rd_en,
	output logic [31:0]                 o_rd_data,
	// Pins
	input  wire logic                   i_exec_pin,
	input  wire logic                   i_init_load_input,
	output logic                        o_pulse,
	output logic                        o_block_out,
	// Status
	output pwmc_pkg::pwmc_status_type   o_status,
	output logic                        o_program_execution_error_flag
);
	import pwmc_pkg::*;

	localparam logic COUNT_ALLOWED = (CHANNEL <= 2);

	logic [15:0]     frequency;
	logic [15:0]     duty_ratio;
	logic [31:0]     preset_pulse_count;
	logic            count_mode;
	logic [31:0]     emitted_pulse_count;
	logic [15:0]     config_error_code;
	logic [15:0]     next_error_code;
	logic            exec_s;
	logic            init_s;
	logic            exec_prev;
	logic            exec_rise;
	logic            exec_fall;
	logic [31:0]     scan_cnt;
	logic            scan_tick;
	pwmc_state_type  state;
	logic [15:0]     run_freq;
	logic [15:0]     quant_freq;
	logic [26:0]     phase;
	logic [27:0]     phase_sum;
	logic            period_end;
	logic [26:0]     high_thr;
	logic [26:0]     next_thr;
	logic [31:0]     pulse_cnt;
	logic [4:0]      duty_step;
	logic [7:0]      duty_q;
	logic            wr_hit_ctrl;

	////////////////////////////////////////////////////////////////
	// Pin synchronisers
	pwmc_sync u_exec_sync
	(
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_async (i_exec_pin),
		.o_sync  (exec_s)
	);

	pwmc_sync u_init_sync
	(
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_async (i_init_load_input),
		.o_sync  (init_s)
	);

	////////////////////////////////////////////////////////////////
	// Scan divider
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			scan_cnt  <= 32'h0000_0000;
			scan_tick <= 1'b0;
		end
		else if (scan_cnt >= 32'(SCAN_CYCLES - 1))
		begin
			scan_cnt  <= 32'h0000_0000;
			scan_tick <= 1'b1;
		end
		else
		begin
			scan_cnt  <= scan_cnt + 32'h0000_0001;
			scan_tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Execution edges, seen once per scan
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			exec_prev <= 1'b0;
		else if (scan_tick)
			exec_prev <= exec_s;
	end

	assign exec_rise = scan_tick & exec_s & ~exec_prev;
	assign exec_fall = scan_tick & ~exec_s & exec_prev;

	////////////////////////////////////////////////////////////////
	// Control registers
	assign wr_hit_ctrl = i_wr_en;

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			frequency          <= `PWMC_INIT_FREQ;
			duty_ratio         <= `PWMC_INIT_DUTY;
			preset_pulse_count <= `PWMC_INIT_PRESET;
			count_mode         <= `PWMC_INIT_MODE;
		end
		else if (init_s && !exec_s)
		begin
			frequency          <= `PWMC_INIT_FREQ;
			duty_ratio         <= `PWMC_INIT_DUTY;
			preset_pulse_count <= `PWMC_INIT_PRESET;
			count_mode         <= `PWMC_INIT_MODE;
		end
		else if (wr_hit_ctrl)
		begin
			case (i_addr)
				`PWMC_ADDR_FREQ:   frequency          <= i_wr_data[15:0];
				`PWMC_ADDR_DUTY:   duty_ratio         <= i_wr_data[15:0];
				`PWMC_ADDR_PRESET: preset_pulse_count <= i_wr_data;
				`PWMC_ADDR_MODE:   count_mode         <= i_wr_data[0] & COUNT_ALLOWED;
				default:           ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Configuration check
	always_comb
	begin
		next_error_code = `PWMC_ERR_NONE;
		if (frequency < `PWMC_FREQ_MIN || frequency > `PWMC_FREQ_MAX)
		begin
			next_error_code = `PWMC_ERR_FREQ;
		end
		else if (duty_ratio < `PWMC_DUTY_MIN || duty_ratio > `PWMC_DUTY_MAX)
		begin
			next_error_code = `PWMC_ERR_DUTY;
		end
		else if (count_mode && (preset_pulse_count < `PWMC_PRESET_MIN ||
			preset_pulse_count > `PWMC_PRESET_MAX))
		begin
			next_error_code = `PWMC_ERR_PRESET;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			config_error_code <= `PWMC_ERR_NONE;
		else if (exec_rise)
			config_error_code <= next_error_code;
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_program_execution_error_flag <= 1'b0;
		else if (exec_rise && next_error_code != `PWMC_ERR_NONE)
			o_program_execution_error_flag <= 1'b1;
		else if (i_wr_en && i_addr == `PWMC_ADDR_ERROR && i_wr_data[`PWMC_ERRCLR_BIT])
			o_program_execution_error_flag <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// Duty quantizer, on the frequency about to be latched while idle
	assign quant_freq = (state == PWMC_RUN) ? run_freq : frequency;

	always_comb
	begin
		duty_step = 5'h01;
		for (int i = 0; i < 20; i++)
		begin
			if ((32'(duty_step) * 32'd50) < 32'(quant_freq))
			begin
				duty_step = duty_step + 5'h01;
			end
		end
		duty_q = 8'h00;
		for (int i = 0; i < 100; i++)
		begin
			if ({8'h00, duty_q} < duty_ratio && duty_q < 8'h64)
			begin
				duty_q = duty_q + {3'h0, duty_step};
			end
		end
		if (duty_q > 8'h64)
		begin
			duty_q = 8'h64;
		end
		next_thr = 27'(32'(duty_q) * `PWMC_PCT_PHASE);
	end

	////////////////////////////////////////////////////////////////
	// Phase accumulator, one period per wrap
	assign phase_sum  = {1'b0, phase} + {12'h000, run_freq};
	assign period_end = (phase_sum >= `PWMC_PHASE_WRAP);

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			phase <= 27'h000_0000;
		end
		else if (state != PWMC_RUN)
		begin
			phase <= 27'h000_0000;
		end
		else if (period_end)
		begin
			phase <= 27'(phase_sum - `PWMC_PHASE_WRAP);
		end
		else
		begin
			phase <= phase_sum[26:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			run_freq <= `PWMC_INIT_FREQ;
		else if (exec_rise && next_error_code == `PWMC_ERR_NONE)
			run_freq <= frequency;
	end

	////////////////////////////////////////////////////////////////
	// Duty threshold, refreshed at each period start
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			high_thr <= 27'h000_0000;
		else if (state != PWMC_RUN || period_end)
			high_thr <= next_thr;
	end

	////////////////////////////////////////////////////////////////
	// Channel sequencer
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state     <= PWMC_IDLE;
			pulse_cnt <= 32'h0000_0000;
			o_status  <= '0;
		end
		else
		begin
			case (state)
				PWMC_IDLE, PWMC_DONE:
				begin
					if (exec_rise && next_error_code == `PWMC_ERR_NONE)
					begin
						state             <= PWMC_RUN;
						pulse_cnt         <= 32'h0000_0001;
						o_status.active   <= 1'b1;
						o_status.complete <= 1'b0;
						o_status.overflow <= 1'b0;
					end
				end
				PWMC_RUN:
				begin
					if (exec_fall)
					begin
						state             <= PWMC_DONE;
						o_status.active   <= 1'b0;
						o_status.complete <= 1'b1;
					end
					else if (period_end && count_mode && pulse_cnt > preset_pulse_count)
					begin
						state             <= PWMC_DONE;
						o_status.overflow <= 1'b1;
						o_status.active   <= 1'b0;
						o_status.complete <= 1'b1;
					end
					else if (period_end && count_mode && pulse_cnt == preset_pulse_count)
					begin
						state             <= PWMC_DONE;
						o_status.active   <= 1'b0;
						o_status.complete <= 1'b1;
					end
					else if (period_end)
					begin
						pulse_cnt <= pulse_cnt + 32'h0000_0001;
					end
				end
				default:
				begin
					state <= PWMC_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Emitted count, refreshed per scan
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			emitted_pulse_count <= 32'h0000_0000;
		else if (scan_tick)
			emitted_pulse_count <= pulse_cnt;
	end

	////////////////////////////////////////////////////////////////
	// Pulse and block outputs
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_pulse <= 1'b0;
		else
			o_pulse <= (state == PWMC_RUN) && (phase < high_thr);
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_block_out <= 1'b0;
		else
			o_block_out <= o_status.complete & exec_s;
	end

	////////////////////////////////////////////////////////////////
	// Register read
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_rd_data <= 32'h0000_0000;
		else if (i_rd_en)
		begin
			case (i_addr)
				`PWMC_ADDR_FREQ:   o_rd_data <= {16'h0000, frequency};
				`PWMC_ADDR_DUTY:   o_rd_data <= {16'h0000, duty_ratio};
				`PWMC_ADDR_PRESET: o_rd_data <= preset_pulse_count;
				`PWMC_ADDR_MODE:   o_rd_data <= {31'h0000_0000, count_mode};
				`PWMC_ADDR_COUNT:  o_rd_data <= emitted_pulse_count;
				`PWMC_ADDR_ERROR:  o_rd_data <= {16'h0000, config_error_code};
				`PWMC_ADDR_STATUS: o_rd_data <= {28'h000_0000, o_program_execution_error_flag,
					o_status.overflow, o_status.complete, o_status.active};
				default:           o_rd_data <= 32'h0000_0000;
			endcase
		end
		else
			o_rd_data <= 32'h0000_0000;
	end
endmodule

// *** src/pwmc_map.svh ***
`ifndef PWMC_MAP_SVH
`define PWMC_MAP_SVH
////////////////////////////////////////////////////////////////
// Register addresses
`define PWMC_ADDR_FREQ      8'h00
`define PWMC_ADDR_DUTY      8'h04
`define PWMC_ADDR_PRESET    8'h08
`define PWMC_ADDR_MODE      8'h0c
`define PWMC_ADDR_COUNT     8'h10
`define PWMC_ADDR_ERROR     8'h14
`define PWMC_ADDR_STATUS    8'h18
////////////////////////////////////////////////////////////////
// Field positions
`define PWMC_STAT_ACTIVE    0
`define PWMC_STAT_COMPLETE  1
`define PWMC_STAT_OVERFLOW  2
`define PWMC_STAT_EXECERR   3
`define PWMC_ERRCLR_BIT     0
////////////////////////////////////////////////////////////////
// Initial load values
`define PWMC_INIT_FREQ      16'h0064
`define PWMC_INIT_DUTY      16'h0032
`define PWMC_INIT_PRESET    32'h0000_0001
`define PWMC_INIT_MODE      1'b0
////////////////////////////////////////////////////////////////
// Limits and error codes
`define PWMC_FREQ_MIN       16'h0001
`define PWMC_FREQ_MAX       16'h03e8
`define PWMC_DUTY_MIN       16'h0001
`define PWMC_DUTY_MAX       16'h0064
`define PWMC_PRESET_MIN     32'h0000_0001
`define PWMC_PRESET_MAX     32'h05f5_e100
`define PWMC_FINE_FREQ      16'h0032
`define PWMC_ERR_NONE       16'h0000
`define PWMC_ERR_FREQ       16'h0001
`define PWMC_ERR_DUTY       16'h0002
`define PWMC_ERR_PRESET     16'h0004
////////////////////////////////////////////////////////////////
// Timing
`define PWMC_CLK_HZ         100000000
`define PWMC_CLK_PERIOD_NS  10
`define PWMC_SCAN_TIME_NS   1000000
`define PWMC_SCAN_CYCLES    (`PWMC_SCAN_TIME_NS / `PWMC_CLK_PERIOD_NS)
`define PWMC_PHASE_WRAP     28'h5f5_e100
`define PWMC_PCT_PHASE      32'h000f_4240
`endif

// *** src/pwmc_pkg.sv ***
package pwmc_pkg;
	typedef enum logic [1:0]
	{
		PWMC_IDLE = 2'b00,
		PWMC_RUN  = 2'b01,
		PWMC_DONE = 2'b10
	} pwmc_state_type;

	typedef struct packed
	{
		logic overflow;
		logic complete;
		logic active;
	} pwmc_status_type;
endpackage

// *** src/pwmc_sync.sv ***
`timescale 1ns/1ps
module pwmc_sync
(
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	// Level in and out
	input  wire logic i_async,
	output logic      o_sync
);
	logic stage_one;

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			stage_one <= 1'b0;
			o_sync    <= 1'b0;
		end
		else
		begin
			stage_one <= i_async;
			o_sync    <= stage_one;
		end
	end
endmodule

// *** verif/pwmc_load_model.sv ***
`timescale 1ns/1ps
module pwmc_load_model
(
	// Clock and reset
	input  wire logic   i_clk,
	input  wire logic   i_rst_b,
	// Pulse pin from the channel
	input  wire logic   i_pulse,
	// Measured high time and pulse count
	output logic [31:0] o_high_cycles,
	output logic [15:0] o_n_high
);
	logic [31:0] run;
	////////////////////////////////////////////////////////////////
	// Load counts clocks of each high phase
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			run <= 32'h0;
			o_high_cycles <= 32'h0;
			o_n_high <= 16'h0;
		end
		else if (i_pulse)
			run <= run + 32'h1;
		else if (run != 32'h0)
		begin
			o_high_cycles <= run;
			o_n_high <= o_n_high + 16'h1;
			run <= 32'h0;
		end
	end
endmodule

// *** verif/pwmc_assertions.sv ***
`timescale 1ns/1ps
`include "pwmc_map.svh"
module pwmc_assertions
#(
	parameter int CHANNEL     = 1,
	parameter int SCAN_CYCLES = 8
)
(
	// Clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_b,
	// Register port
	input  wire logic [7:0]           i_addr,
	input  wire logic [31:0]          i_wr_data,
	input  wire logic                 i_wr_en,
	input  wire logic                 i_rd_en,
	input  wire logic [31:0]          o_rd_data,
	// Pins and status
	input  wire logic                 i_exec_pin,
	input  wire logic                 i_init_load_input,
	input  wire logic                 o_pulse,
	input  wire logic                 o_block_out,
	input  wire pwmc_pkg::pwmc_status_type o_status,
	input  wire logic                 o_program_execution_error_flag
);
	import pwmc_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	////////////////////////////////////////////////////////////////
	// Checks
	a_rd_idle_zero: assert property (!$past(i_rd_en) |-> o_rd_data == 32'h0)
		else $error("read data not zero outside read cycle");
	a_err_clear_only: assert property ($fell(o_program_execution_error_flag) |->
		$past(i_wr_en && i_addr == `PWMC_ADDR_ERROR && i_wr_data[0]))
		else $error("error flag fell without clear write");
	a_err_no_start: assert property ($rose(o_program_execution_error_flag) |-> !$rose(o_status.active))
		else $error("start despite bad setup");
	a_start_clean: assert property ($rose(o_status.active) |-> !o_status.complete && !o_status.overflow)
		else $error("start left complete or overflow set");
	a_active_complete_excl: assert property (!(o_status.active && o_status.complete))
		else $error("active and complete both set");
	a_pulse_needs_active: assert property (o_pulse |-> o_status.active || $past(o_status.active))
		else $error("pulse while not active");
	a_block_needs_done: assert property (o_block_out |-> o_status.complete || $past(o_status.complete))
		else $error("block output without complete");
	a_block_exec_low: assert property (!i_exec_pin [*4] |=> !o_block_out)
		else $error("block output high with execution off");
	a_start_needs_exec: assert property (!i_exec_pin [*4] |=> !$rose(o_status.active))
		else $error("start with execution off");
	////////////////////////////////////////////////////////////////
	// Coverage
	c_start: cover property ($rose(o_status.active));
	c_error: cover property ($rose(o_program_execution_error_flag));
	c_stop: cover property ($fell(o_status.active) ##1 o_status.complete);
endmodule
bind pwmc_top pwmc_assertions #(.CHANNEL(CHANNEL), .SCAN_CYCLES(SCAN_CYCLES)) u_chk (.i_clk(i_clk),
	.i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
	.o_rd_data(o_rd_data), .i_exec_pin(i_exec_pin), .i_init_load_input(i_init_load_input),
	.o_pulse(o_pulse), .o_block_out(o_block_out), .o_status(o_status),
	.o_program_execution_error_flag(o_program_execution_error_flag));

// *** verif/tb.sv ***
`timescale 1ns/1ps
`include "pwmc_map.svh"
module tb;
	import pwmc_pkg::*;
	localparam int SC = 8;
	logic            i_clk, i_rst_b, i_wr_en, i_rd_en, i_exec_pin, i_init_load_input;
	logic [7:0]      i_addr;
	logic [31:0]     i_wr_data, o_rd_data, rd_val, high_len;
	logic            o_pulse, o_block_out, o_program_execution_error_flag;
	logic [15:0]     n_high;
	logic [31:0]     rd_data_ch3, rd_val_ch3;
	pwmc_status_type o_status;
	int              num_errors, n_compared;
	// Bad setups: frequency, duty, mode, preset, code
	logic [31:0]     tf [6] = '{32'h0, 32'h3e9, 32'h3e8, 32'h3e8, 32'h3e8, 32'h3e8};
	logic [31:0]     td [6] = '{32'h32, 32'h32, 32'h0, 32'h65, 32'h32, 32'h32};
	logic [31:0]     tm [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h1};
	logic [31:0]     tp [6] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h0, 32'h05f5_e101};
	logic [31:0]     tc [6] = '{32'h1, 32'h1, 32'h2, 32'h2, 32'h4, 32'h4};
	// Reset map: address and value
	logic [7:0]      ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
	logic [31:0]     rv [8] = '{32'h64, 32'h32, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	////////////////////////////////////////////////////////////////
	pwmc_top #(.CHANNEL(1), .SCAN_CYCLES(SC)) uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
		.i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
		.i_exec_pin(i_exec_pin), .i_init_load_input(i_init_load_input), .o_pulse(o_pulse),
		.o_block_out(o_block_out), .o_status(o_status),
		.o_program_execution_error_flag(o_program_execution_error_flag));
	// Third channel shares the bus, to show that it cannot count
	pwmc_top #(.CHANNEL(3), .SCAN_CYCLES(SC)) uut_ch3 (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
		.i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(rd_data_ch3),
		.i_exec_pin(i_exec_pin), .i_init_load_input(i_init_load_input), .o_pulse(), .o_block_out(),
		.o_status(), .o_program_execution_error_flag());
	pwmc_load_model u_load (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_pulse(o_pulse),
		.o_high_cycles(high_len), .o_n_high(n_high));
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	////////////////////////////////////////////////////////////////
	// Bus and pin tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr_en <= 1'b1;
		i_addr <= a;
		i_wr_data <= d;
		@(posedge i_clk);
		i_wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		i_rd_en <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd_en <= 1'b0;
		#1 rd_val = o_rd_data;
		rd_val_ch3 = rd_data_ch3;
	endtask
	task automatic exec(input logic v);
		@(posedge i_clk);
		i_exec_pin <= v;
		repeat (3 * SC) @(posedge i_clk);
	endtask
	task automatic print_verdict;
		$display("compared %0d, wrong %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge i_clk);
		num_errors++;
		print_verdict;
	end
	////////////////////////////////////////////////////////////////
	// Tests
	initial
	begin
		i_rst_b = 1'b0;
		i_wr_en = 1'b0;
		i_rd_en = 1'b0;
		i_addr = 8'h0;
		i_wr_data = 32'h0;
		i_exec_pin = 1'b0;
		i_init_load_input = 1'b0;
		repeat (4) @(posedge i_clk);
		i_rst_b <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			rd(ra[i]);
			check(rd_val, rv[i]);
		end
		wr(`PWMC_ADDR_MODE, 32'h1);
		rd(`PWMC_ADDR_MODE);
		check(rd_val, 32'h1);
		check(rd_val_ch3, 32'h0);
		$display("test reset values done");
		for (int i = 0; i < 6; i++)
		begin
			wr(`PWMC_ADDR_FREQ, tf[i]);
			wr(`PWMC_ADDR_DUTY, td[i]);
			wr(`PWMC_ADDR_MODE, tm[i]);
			wr(`PWMC_ADDR_PRESET, tp[i]);
			exec(1'b1);
			rd(`PWMC_ADDR_ERROR);
			check(rd_val, tc[i]);
			check(o_program_execution_error_flag, 1'b1);
			check(o_status.active, 1'b0);
			wr(`PWMC_ADDR_ERROR, 32'h1);
			exec(1'b0);
			check(o_program_execution_error_flag, 1'b0);
		end
		$display("test bad setups done");
		wr(`PWMC_ADDR_FREQ, 32'h3e8);
		wr(`PWMC_ADDR_DUTY, 32'h1);
		wr(`PWMC_ADDR_MODE, 32'h0);
		exec(1'b1);
		check(o_status.active, 1'b1);
		rd(`PWMC_ADDR_ERROR);
		check(rd_val, 32'h0);
		rd(`PWMC_ADDR_COUNT);
		check(rd_val, 32'h1);
		@(posedge i_clk);
		i_init_load_input <= 1'b1;
		repeat (3 * SC) @(posedge i_clk);
		rd(`PWMC_ADDR_FREQ);
		check(rd_val, 32'h3e8);
		for (int k = 0; k < 30000 && n_high == 16'h0; k++)
			@(posedge i_clk);
		check(high_len, 32'h4e20);
		check(o_status.active, 1'b1);
		exec(1'b0);
		check(o_status.active, 1'b0);
		check(o_status.complete, 1'b1);
		check(o_block_out, 1'b0);
		rd(`PWMC_ADDR_FREQ);
		check(rd_val, 32'h64);
		$display("test run and stop done");
		print_verdict;
	end
endmodule
